// ==== hw/qrps_map.svh ====
// timing and width constants for the quad rail power sequencer
`ifndef QRPS_MAP_SVH
`define QRPS_MAP_SVH
`define QRPS_CLK_MHZ 250
`define QRPS_LONG_MS 190
`define QRPS_SHORT_US 30
// long window in cycles: 190 ms at 250 MHz, exact
`define QRPS_LONG_CYC (`QRPS_LONG_MS * 1000 * `QRPS_CLK_MHZ)
// short window in cycles: 30 us at 250 MHz
`define QRPS_SHORT_CYC (`QRPS_SHORT_US * `QRPS_CLK_MHZ)
`define QRPS_CNT_W 26
`endif

// ==== hw/qrps_pkg.sv ====
// types for the quad rail power sequencer
package qrps_pkg;
  typedef enum logic [2:0] {
    QRPS_RESET,
    QRPS_ONE_ON,
    QRPS_TWO_ON,
    QRPS_THREE_ON,
    QRPS_GOOD
  } qrps_state_e;
endpackage : qrps_pkg

// ==== hw/qrps_sequencer.sv ====
// four-rail power-up sequencer and supply monitor core
// Operation
// - from reset, enable one asserts after the main rail is high for 190 ms.
// - with one on, enable two asserts after rails one and two are high 30 us.
// - with two on, enable three asserts after rails one and three high 30 us.
// - with three on, supplies good asserts after all four high for 190 ms.
// - once good, enables stop following their individual sequencing inputs.
// - when good, rail two, three or four low for 30 us drops good only.
// - a fault on rails two to four keeps all three enables asserted.
// - when good, main rail low for 30 us drops good and all enables to reset.
// - in reset, a low main rail keeps enable one inactive.
`timescale 1ns/1ps
`include "qrps_map.svh"
module qrps_sequencer
  import qrps_pkg::*;
#(
  parameter int LONG_CYC = `QRPS_LONG_CYC,
  parameter int SHORT_CYC = `QRPS_SHORT_CYC
)
(
  input wire logic core_clk, // 250 MHz clock
  input wire logic sys_rst, // synchronous reset, active high
  input wire logic mainRailSense, // rail one above trip point
  input wire logic railTwoSense, // rail two above trip point
  input wire logic railThreeSense, // rail three above trip point
  input wire logic railFourSense, // rail four above trip point
  output logic regulatorOneEnable, // enable for regulator one
  output logic regulatorTwoEnable, // enable for regulator two
  output logic regulatorThreeEnable, // enable for regulator three
  output logic suppliesGood // all supplies good
);
  localparam int CW = `QRPS_CNT_W;

  typedef struct packed {
    qrps_state_e state;
    logic [CW-1:0] count;
    logic en1;
    logic en2;
    logic en3;
    logic good;
  } qrps_regs_s;

  qrps_regs_s cur;
  qrps_regs_s next_cur;
  logic [3:0] sense;
  logic cond;
  logic [CW-1:0] target;
  logic reached;

  // ---------------------------------------------------------------
  // input synchronisation
  // ---------------------------------------------------------------
  qrps_sync #(.WIDTH(4)) u_sync (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .rawIn({railFourSense, railThreeSense, railTwoSense, mainRailSense}),
    .syncOut(sense)
  );

  // count reaches the window length minus one: condition held long enough
  function automatic logic windowDone(input logic [CW-1:0] cnt,
                                      input logic [CW-1:0] len);
    windowDone = (cnt >= len - 1'b1);
  endfunction : windowDone

  // ---------------------------------------------------------------
  // sequencing state machine
  // ---------------------------------------------------------------
  // condition and window for the current state; a main-rail fault in
  // good beats a rail two to four fault, so it is checked first
  always_comb
  begin
    cond = 1'b0;
    target = CW'(SHORT_CYC);
    case (cur.state)
      QRPS_RESET:
      begin
        cond = sense[0];
        target = CW'(LONG_CYC);
      end
      QRPS_ONE_ON:
        cond = sense[0] & sense[1];
      QRPS_TWO_ON:
        cond = sense[0] & sense[2];
      QRPS_THREE_ON:
      begin
        cond = &sense;
        target = CW'(LONG_CYC);
      end
      QRPS_GOOD:
        cond = ~(&sense);
      default:
        cond = 1'b0;
    endcase
  end

  assign reached = cond && windowDone(cur.count, target);

  // next-state logic; counter restarts whenever cond drops
  always_comb
  begin
    next_cur = cur;
    next_cur.count = cond ? cur.count + 1'b1 : '0;
    case (cur.state)
      QRPS_RESET:
        if (reached)
        begin
          next_cur.state = QRPS_ONE_ON;
          next_cur.en1 = 1'b1;
          next_cur.count = '0;
        end
      QRPS_ONE_ON:
        if (reached)
        begin
          next_cur.state = QRPS_TWO_ON;
          next_cur.en2 = 1'b1;
          next_cur.count = '0;
        end
      QRPS_TWO_ON:
        if (reached)
        begin
          next_cur.state = QRPS_THREE_ON;
          next_cur.en3 = 1'b1;
          next_cur.count = '0;
        end
      QRPS_THREE_ON:
        // good needs all three enables as well
        if (reached && cur.en1 && cur.en2 && cur.en3)
        begin
          next_cur.state = QRPS_GOOD;
          next_cur.good = 1'b1;
          next_cur.count = '0;
        end
      QRPS_GOOD:
        // enables ignore sequencing inputs here
        if (reached)
        begin
          next_cur.good = 1'b0;
          next_cur.count = '0;
          if (!sense[0])
          begin
            next_cur.state = QRPS_RESET;
            next_cur.en1 = 1'b0;
            next_cur.en2 = 1'b0;
            next_cur.en3 = 1'b0;
          end
          else
            next_cur.state = QRPS_THREE_ON;
        end
      default:
        next_cur = '0;
    endcase
  end

  // state register; reset clears everything
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
      cur <= '0;
    else
      cur <= next_cur;
  end

  assign regulatorOneEnable = cur.en1;
  assign regulatorTwoEnable = cur.en2;
  assign regulatorThreeEnable = cur.en3;
  assign suppliesGood = cur.good;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  reset_clear_a: assert property (@(posedge core_clk)
    sys_rst |=> (cur == '0))
    else $error("reset did not clear state");

  first_enable_a: assert property (@(posedge core_clk)
    disable iff (sys_rst)
    $rose(cur.en1) |-> $past(cur.state) == QRPS_RESET
      && $past(cur.count) == CW'(LONG_CYC - 1))
    else $error("enable one rose without full long window");

  main_low_hold_a: assert property (@(posedge core_clk)
    disable iff (sys_rst)
    (cur.state == QRPS_RESET && !sense[0]) |=> !cur.en1)
    else $error("enable one asserted with main rail low");

  second_enable_a: assert property (@(posedge core_clk)
    disable iff (sys_rst)
    $rose(cur.en2) |-> $past(cur.en1) && $past(sense[1])
      && $past(cur.count) == CW'(SHORT_CYC - 1))
    else $error("enable two rose early");

  third_enable_a: assert property (@(posedge core_clk)
    disable iff (sys_rst)
    $rose(cur.en3) |-> $past(cur.en2) && $past(sense[2]) && $past(sense[0])
      && $past(cur.count) == CW'(SHORT_CYC - 1))
    else $error("enable three rose without rails");

  good_needs_en_a: assert property (@(posedge core_clk)
    disable iff (sys_rst)
    cur.good |-> cur.en1 && cur.en2 && cur.en3)
    else $error("good without all enables");

  good_mode_hold_a: assert property (@(posedge core_clk)
    disable iff (sys_rst)
    (cur.state == QRPS_GOOD && sense[0]) |=> cur.en2 && cur.en3)
    else $error("enables followed inputs in good mode");

  rail_fault_a: assert property (@(posedge core_clk)
    disable iff (sys_rst)
    (cur.state == QRPS_GOOD && sense[0] && reached)
      |=> !cur.good && cur.state == QRPS_THREE_ON)
    else $error("rail fault did not drop good");

  rail_fault_keep_a: assert property (@(posedge core_clk)
    disable iff (sys_rst)
    $fell(cur.good) && !$past(sys_rst) && $past(sense[0])
      |-> cur.en1 && cur.en2 && cur.en3)
    else $error("rail fault dropped enables");

  main_fault_a: assert property (@(posedge core_clk)
    disable iff (sys_rst)
    (cur.state == QRPS_GOOD && !sense[0] && reached)
      |=> cur.state == QRPS_RESET && !cur.en1 && !cur.en2 && !cur.en3
        && !cur.good)
    else $error("main fault did not reset");

  window_restart_a: assert property (@(posedge core_clk)
    disable iff (sys_rst)
    !cond |=> cur.count == '0)
    else $error("window counter did not restart");
endmodule : qrps_sequencer

// ==== hw/qrps_sync.sv ====
// three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
module qrps_sync
#(
  parameter int WIDTH = 4
)
(
  input wire logic core_clk, // system clock
  input wire logic sys_rst, // synchronous reset, active high
  input wire logic [WIDTH-1:0] rawIn, // asynchronous pins
  output logic [WIDTH-1:0] syncOut // filtered level
);
  typedef struct packed {
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
    logic [WIDTH-1:0] stage3;
    logic [WIDTH-1:0] level;
  } qrps_sync_s;

  qrps_sync_s cur;
  qrps_sync_s next_cur;

  // stage1 only feeds stage2; level changes once stages 2 and 3 agree,
  // so a metastable first sample never reaches the sequencer
  always_comb
  begin
    next_cur = cur;
    next_cur.stage1 = rawIn;
    next_cur.stage2 = cur.stage1;
    next_cur.stage3 = cur.stage2;
    for (int i = 0; i < WIDTH; i++)
    begin
      if (cur.stage2[i] == cur.stage3[i])
        next_cur.level[i] = cur.stage3[i];
    end
  end

  // register bank; reset empties the pipe so no stale level survives
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
      cur <= '0;
    else
      cur <= next_cur;
  end

  assign syncOut = cur.level;
endmodule : qrps_sync

// ==== sim/qrps_rail_model.sv ====
// regulator bank and rail comparators facing the sequencer
`timescale 1ns/1ps
module qrps_rail_model
#(
  parameter int DLY = 3
)
(
  input wire logic core_clk, // sequencer clock
  input wire logic mainOn, // main supply present
  input wire logic [3:0] faultMask, // rails forced low
  input wire logic [2:0] enables, // regulator enables
  output logic [3:0] senses // comparator levels
);
  logic [2:0] ramp [DLY];
  // -------------------------------
  // regulators
  // -------------------------------
  // a rail rises DLY cycles after its enable, so it is never instant
  always_ff @(posedge core_clk)
  begin
    ramp[0] <= enables;
    for (int i = 1; i < DLY; i++)
      ramp[i] <= ramp[i-1] & enables;
  end
  // a dropped enable kills its rail at once
  assign senses = {ramp[DLY-1] & enables, mainOn} & ~faultMask;
endmodule : qrps_rail_model

// ==== sim/tb.sv ====
// self-checking bench for the quad rail power sequencer
`timescale 1ns/1ps
module tb;
  localparam int LC = 40;
  localparam int SC = 8;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic mainOn = 1'b0;
  logic [3:0] faultMask = 4'h0;
  logic [3:0] senses;
  wire logic [3:0] outs;
  int nMismatch = 0;
  int nTests = 0;
  int seed = 63;
  int expSt = 0;
  // -------------------------------
  // clock and instances
  // -------------------------------
  always #2 core_clk = ~core_clk;
  qrps_rail_model rails (.core_clk(core_clk), .mainOn(mainOn),
    .faultMask(faultMask), .enables(outs[2:0]), .senses(senses));
  qrps_sequencer #(.LONG_CYC(LC), .SHORT_CYC(SC)) dut (
    .core_clk(core_clk), .sys_rst(sys_rst),
    .mainRailSense(senses[0]), .railTwoSense(senses[1]),
    .railThreeSense(senses[2]), .railFourSense(senses[3]),
    .regulatorOneEnable(outs[0]), .regulatorTwoEnable(outs[1]),
    .regulatorThreeEnable(outs[2]), .suppliesGood(outs[3]));
  // -------------------------------
  // model and tasks
  // -------------------------------
  // state n has the n lowest outputs high
  function automatic logic [3:0] model(input int s);
    return 4'((1 << s) - 1);
  endfunction : model
  task automatic chk(input logic [3:0] seen, input logic [3:0] want);
    nTests++;
    if (seen !== want)
    begin
      nMismatch++;
      $display("[FAIL] %0t outputs %b, expected %b", $time, seen, want);
    end
  endtask : chk
  // drive at the edge, then let it settle
  task automatic setIn(input logic m, input logic [3:0] f);
    @(posedge core_clk);
    mainOn <= m;
    faultMask <= f;
    #1;
  endtask : setIn
  task automatic hold(input int n);
    repeat (n)
    begin
      @(posedge core_clk);
      #1;
      chk(outs, model(expSt));
    end
  endtask : hold
  // wait for next state; every cycle in between must show the old one
  task automatic adv(input int st, input int lo, input int hi);
    int n;
    n = 0;
    while (outs !== model(st) && n <= hi)
    begin
      @(posedge core_clk);
      #1;
      n++;
      if (outs !== model(st))
        chk(outs, model(expSt));
    end
    chk({3'h0, n >= lo && n <= hi}, 4'h1);
    chk(outs, model(st));
    expSt = st;
  endtask : adv
  task automatic wrapUp;
    $display("comparisons %0d, mismatches %0d", nTests, nMismatch);
    if (nMismatch == 0 && nTests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : wrapUp
  // -------------------------------
  // scenarios
  // -------------------------------
  initial
  begin
    int g;
    repeat (4) @(posedge core_clk);
    sys_rst <= 1'b0;
    #1;
    chk(outs, 4'h0);
    hold(10);
    // main rail blip shorter than the long window
    g = 1 + $unsigned($random(seed)) % (LC - 6);
    setIn(1'b1, 4'h0);
    hold(g);
    setIn(1'b0, 4'h0);
    hold(LC + 10);
    setIn(1'b1, 4'h0);
    adv(1, LC, LC + 10);
    adv(2, SC, SC + 12);
    adv(3, SC, SC + 12);
    adv(4, LC, LC + 15);
    // each of rails two to four: blip, then a real fault
    for (int r = 1; r < 4; r++)
    begin
      g = 1 + $unsigned($random(seed)) % (SC - 4);
      setIn(1'b1, 4'(1 << r));
      hold(g);
      setIn(1'b1, 4'h0);
      hold(SC + 8);
      setIn(1'b1, 4'(1 << r));
      adv(3, SC, SC + 8);
      hold(6);
      setIn(1'b1, 4'h0);
      adv(4, LC, LC + 10);
    end
    g = 1 + $unsigned($random(seed)) % (SC - 4);
    setIn(1'b0, 4'h0);
    hold(g);
    setIn(1'b1, 4'h0);
    hold(SC + 8);
    setIn(1'b0, 4'h0);
    adv(0, SC, SC + 8);
    hold(LC + 10);
    // reset in mid-sequence must also clear the timers
    setIn(1'b1, 4'h0);
    adv(1, LC, LC + 10);
    adv(2, SC, SC + 12);
    adv(3, SC, SC + 12);
    hold(20);
    @(posedge core_clk);
    sys_rst <= 1'b1;
    expSt = 0;
    hold(3);
    @(posedge core_clk);
    sys_rst <= 1'b0;
    adv(1, LC, LC + 10);
    wrapUp();
  end
  // watchdog at 10000 cycles, far beyond the under 1000 cycles the run needs
  initial
  begin
    #40000;
    nMismatch++;
    wrapUp();
  end
endmodule : tb
